/* rtl/apm_device.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Amplifier protection and monitor
// ----------------------------------------
module apm_device #(
  parameter int SC_CYC = apm_pkg::SC_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Link
  apm_link_if.dev lk,
  // Strap
  input wire logic [1:0] addr_sel_i,
  // Analog detectors
  input wire logic [3:0] avg_over_i,
  input wire logic [3:0] peak_over_i,
  input wire logic [3:0] full_duty_i,
  input wire logic [3:0] tweet_det_i,
  input wire logic [3:0][7:0] dc_offset_i,
  input wire logic [7:0] temp_i,
  // Supply comparators
  input wire logic bat_low_i,
  input wire logic an_low_i,
  input wire logic pump_low_i,
  input wire logic bat_high_i,
  input wire logic por_i,
  // Power stage control
  output logic [3:0] drive_o,
  output logic [3:0] pulse_trim_o,
  output logic [3:0] peak_limit_o,
  output logic [3:0][1:0] gain_o,
  // Oscillator role and bus address
  output logic [1:0] osc_role_o,
  output logic [6:0] bus_addr_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic lk_prev; // Previous link clock
    logic ack; // Acknowledge level
    logic oe; // Link drivers on
    logic [7:0] rdata; // Read answer
    logic [3:0][1:0] gain; // Gain codes
    logic dc_en; // DC shutdown enable
    logic [7:0] dc_lvl; // DC level
    logic [7:0] dc_time; // DC time
    apm_pkg::apm_ind_t ind_mode; // Indicator function
    logic [3:0] play; // Channel play request
    logic [3:0] sc_flt; // Short faults
    logic [3:0] dc_flt; // DC detections
    logic [4:0] sup_flt; // Supply and thermal faults
    logic [2:0] warn; // Thermal warning levels
    logic [3:0][15:0] sc_cnt; // Short duration
    logic [3:0][15:0] dc_cnt; // DC duration
    logic strap_done; // Strap captured
    logic [1:0] role; // Oscillator role
    logic [6:0] bus_addr; // Bus address
    logic [3:0] drive; // Channel switching
    logic [3:0] trim; // Pulse trim
    logic [3:0] plim; // Peak limit
    logic [3:0][1:0] gain_eff; // Folded gain
    logic fault; // Fault pin
    logic ind; // Indicator pin
  } apm_dev_t;

  apm_dev_t st_reg;
  apm_dev_t st_next;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [82:0] raw; // Asynchronous inputs, topped by a constant one
  logic [82:0] syn; // Synchronised inputs
  logic [1:0] s_sel;
  logic s_clk, s_req, s_wr, s_por, s_live; // s_live: synchroniser filled after reset
  logic [7:0] s_addr, s_wdata, s_temp;
  logic [3:0] s_avg, s_peak, s_full, s_tweet;
  logic [3:0] s_sup;
  logic [3:0][7:0] s_off;

  assign raw = {1'b1, addr_sel_i, lk.lk_clk, lk.req, lk.wr, lk.addr, lk.wdata, avg_over_i, peak_over_i,
                full_duty_i, tweet_det_i, bat_low_i, an_low_i, pump_low_i, bat_high_i, por_i,
                temp_i, dc_offset_i};
  assign {s_live, s_sel, s_clk, s_req, s_wr, s_addr, s_wdata, s_avg, s_peak, s_full, s_tweet,
          s_sup, s_por, s_temp, s_off} = syn;

  apm_sync #(.W(83)) u_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .d_i(raw),
    .q_o(syn)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic edge_up, glob_off;
    logic acc, wr_en;
    logic [3:0] ch_clr;
    logic [4:0] sup_set;
    logic [1:0] nwarn, g;
    st_next = st_reg;
    glob_off = 1'b0;
    g = 2'h0;
    sup_set = '0;
    nwarn = 2'(st_reg.warn[0]) + 2'(st_reg.warn[1]) + 2'(st_reg.warn[2]);
    edge_up = s_clk & ~st_reg.lk_prev;
    acc = edge_up & s_req & ~st_reg.ack;
    wr_en = acc & s_wr;
    ch_clr = '0;
    st_next.lk_prev = s_clk;
    st_next.oe = ~s_por;
    // Four phase access on link clock rising edge
    if (acc)
    begin
      st_next.ack = 1'b1;
      if (!s_wr)
      begin
        if (s_addr == apm_pkg::R_FLT_CH)
          st_next.rdata = {st_reg.dc_flt, st_reg.sc_flt};
        else if (s_addr == apm_pkg::R_FLT_SUP)
          st_next.rdata = {3'h0, st_reg.sup_flt};
        else if (s_addr == apm_pkg::R_THERM)
          st_next.rdata = {st_reg.warn, 5'h00};
        else if (s_addr == apm_pkg::R_GAIN)
          st_next.rdata = st_reg.gain;
        else if (s_addr == apm_pkg::R_DC_CFG)
          st_next.rdata = {7'h00, st_reg.dc_en};
        else if (s_addr == apm_pkg::R_DC_LVL)
          st_next.rdata = st_reg.dc_lvl;
        else if (s_addr == apm_pkg::R_DC_TIME)
          st_next.rdata = st_reg.dc_time;
        else if (s_addr == apm_pkg::R_IND)
          st_next.rdata = {6'h00, st_reg.ind_mode};
        else if (s_addr == apm_pkg::R_CHAN)
          st_next.rdata = {4'h0, st_reg.play};
        else
          st_next.rdata = 8'h00;
      end
    end
    else if (edge_up && !s_req)
      st_next.ack = 1'b0;
    // Register writes
    if (wr_en)
    begin
      if (s_addr == apm_pkg::R_GAIN)
        st_next.gain = s_wdata;
      else if (s_addr == apm_pkg::R_DC_CFG)
        st_next.dc_en = s_wdata[0];
      else if (s_addr == apm_pkg::R_DC_LVL)
        st_next.dc_lvl = s_wdata;
      else if (s_addr == apm_pkg::R_DC_TIME)
        st_next.dc_time = s_wdata;
      else if (s_addr == apm_pkg::R_IND)
        st_next.ind_mode = apm_pkg::apm_ind_t'(s_wdata[1:0]);
      else if (s_addr == apm_pkg::R_CHAN)
      begin
        st_next.play = s_wdata[3:0];
        ch_clr = s_wdata[3:0];
      end
    end
    // Thermal warning levels with hysteresis
    for (int k = 0; k < 3; k++)
    begin
      if (st_reg.warn[k])
        st_next.warn[k] = s_temp >= (apm_pkg::TW_THR[k] - apm_pkg::TW_HYST);
      else
        st_next.warn[k] = s_temp >= apm_pkg::TW_THR[k];
    end
    // Supply and thermal faults, set wins over clear
    sup_set[apm_pkg::SUP_BAT_LO] = s_sup[3];
    sup_set[apm_pkg::SUP_AN_LO] = s_sup[2];
    sup_set[apm_pkg::SUP_PUMP_LO] = s_sup[1];
    sup_set[apm_pkg::SUP_BAT_HI] = s_sup[0];
    sup_set[apm_pkg::SUP_TSD] = s_temp >= apm_pkg::TSD_TEMP;
    if (wr_en && s_addr == apm_pkg::R_FLT_SUP)
      st_next.sup_flt = (st_reg.sup_flt & ~s_wdata[4:0]) | sup_set;
    else if (wr_en && s_addr == apm_pkg::R_CHAN && ch_clr != 4'h0)
      st_next.sup_flt = sup_set;
    else
      st_next.sup_flt = st_reg.sup_flt | sup_set;
    glob_off = |st_next.sup_flt;
    // Per channel protection
    for (int i = 0; i < 4; i++)
    begin
      // Short duration count while switching into a peak overcurrent
      if (s_peak[i] && st_reg.drive[i])
      begin
        if (st_reg.sc_cnt[i] >= 16'(SC_CYC - 1))
          st_next.sc_flt[i] = 1'b1;
        else
          st_next.sc_cnt[i] = st_reg.sc_cnt[i] + 16'h0001;
      end
      else
        st_next.sc_cnt[i] = 16'h0000;
      // DC offset duration count
      if (st_reg.drive[i] && st_reg.dc_lvl != 8'h00 && s_off[i] >= st_reg.dc_lvl)
      begin
        if (st_reg.dc_cnt[i] >= (16'(st_reg.dc_time) << apm_pkg::DC_TIME_SHIFT))
          st_next.dc_flt[i] = 1'b1;
        else
          st_next.dc_cnt[i] = st_reg.dc_cnt[i] + 16'h0001;
      end
      else
        st_next.dc_cnt[i] = 16'h0000;
      // Restart clears the channel fault unless it is set again now
      if (ch_clr[i] && !(st_next.sc_flt[i] && !st_reg.sc_flt[i]))
        st_next.sc_flt[i] = 1'b0;
      if (ch_clr[i] && !(st_next.dc_flt[i] && !st_reg.dc_flt[i]))
        st_next.dc_flt[i] = 1'b0;
      // Immediate stop on any short or supply fault, or on a DC fault when enabled, no ramp
      st_next.drive[i] = st_next.play[i] & ~st_next.sc_flt[i] & ~glob_off
                         & ~(st_next.dc_flt[i] & st_reg.dc_en);
      st_next.trim[i] = s_avg[i] & st_next.drive[i];
      st_next.plim[i] = s_peak[i] & st_next.drive[i];
      // Foldback lowers gain one step per warning level
      g = st_reg.gain[i];
      st_next.gain_eff[i] = (g > nwarn) ? 2'(g - nwarn) : 2'h0;
    end
    // Fault pin
    st_next.fault = |st_next.sc_flt | |(st_next.dc_flt & {4{st_reg.dc_en}}) | glob_off;
    // Shared indicator pin
    case (st_reg.ind_mode)
      apm_pkg::IND_CLIP: st_next.ind = |(s_full & st_reg.drive);
      apm_pkg::IND_BOTH: st_next.ind = |(s_full & st_reg.drive) | st_reg.warn[0];
      apm_pkg::IND_TWEET: st_next.ind = |s_tweet;
      default: st_next.ind = st_reg.warn[0];
    endcase
    // Strap capture once the synchroniser holds pin levels
    if (!st_reg.strap_done && s_live)
    begin
      st_next.strap_done = 1'b1;
      st_next.role = s_sel;
      st_next.bus_addr = apm_pkg::BUS_ADDR_BASE | {5'h00, s_sel};
    end
    // Power-on reset returns everything but the strap and the previous link clock to defaults
    if (s_por)
    begin
      st_next = '0;
      st_next.lk_prev = s_clk;
      st_next.strap_done = st_reg.strap_done;
      st_next.role = st_reg.role;
      st_next.bus_addr = st_reg.bus_addr;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign lk.rd_data = st_reg.rdata;
  assign lk.rd_oe = st_reg.oe;
  assign lk.ack = st_reg.ack;
  assign lk.ack_oe = st_reg.oe;
  assign lk.fault = st_reg.fault;
  assign lk.ind = st_reg.ind;
  assign drive_o = st_reg.drive;
  assign pulse_trim_o = st_reg.trim;
  assign peak_limit_o = st_reg.plim;
  assign gain_o = st_reg.gain_eff;
  assign osc_role_o = st_reg.role;
  assign bus_addr_o = st_reg.bus_addr;
endmodule

/* shared/apm_pkg.sv */
package apm_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int CLK_NS = 5;
  localparam int SC_MIN_US = 200;
  localparam int SC_MAX_US = 390;
  localparam int SC_CYC = SC_MIN_US * CLK_MHZ;
  localparam int LK_PERIOD_NS = 125;
  localparam int LK_HALF = LK_PERIOD_NS / (2 * CLK_NS);
  localparam int DC_TIME_SHIFT = 8;
  // ----------------------------------------
  // Device register map (link side)
  // ----------------------------------------
  localparam logic [7:0] R_FLT_CH = 8'h00;
  localparam logic [7:0] R_FLT_SUP = 8'h01;
  localparam logic [7:0] R_THERM = 8'h04;
  localparam logic [7:0] R_GAIN = 8'h05;
  localparam logic [7:0] R_DC_CFG = 8'h06;
  localparam logic [7:0] R_DC_LVL = 8'h07;
  localparam logic [7:0] R_DC_TIME = 8'h08;
  localparam logic [7:0] R_IND = 8'h0A;
  localparam logic [7:0] R_CHAN = 8'h0C;
  // Supply fault bit positions
  localparam int SUP_BAT_LO = 0;
  localparam int SUP_AN_LO = 1;
  localparam int SUP_PUMP_LO = 2;
  localparam int SUP_BAT_HI = 3;
  localparam int SUP_TSD = 4;
  // Indicator functions
  typedef enum logic [1:0] {
    IND_THERM = 2'h0,
    IND_CLIP = 2'h1,
    IND_BOTH = 2'h2,
    IND_TWEET = 2'h3
  } apm_ind_t;
  // Temperatures in degrees C, then the strap bus address base
  localparam logic [2:0][7:0] TW_THR = {8'h87, 8'h7D, 8'h73};
  localparam logic [7:0] TW_HYST = 8'h0A;
  localparam logic [7:0] TSD_TEMP = 8'h96;
  localparam logic [6:0] BUS_ADDR_BASE = 7'h6C;
  // ----------------------------------------
  // Controller APB map
  // ----------------------------------------
  localparam logic [7:0] A_LK_ADDR = 8'h00;
  localparam logic [7:0] A_LK_WDATA = 8'h04;
  localparam logic [7:0] A_LK_GO = 8'h08;
  localparam logic [7:0] A_LK_STAT = 8'h0C;
  localparam logic [7:0] A_LK_RDATA = 8'h10;
  localparam int GO_WR = 0;
  localparam int GO_RD = 1;
  typedef enum logic [2:0] {
    CS_IDLE = 3'h1,
    CS_REQ = 3'h2,
    CS_REL = 3'h4
  } apm_cst_t;
endpackage

/* shared/apm_link_if.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Controller to amplifier link
// ----------------------------------------
interface apm_link_if;
  logic lk_clk; // Link clock from controller
  logic req; // Access request level
  logic wr; // Write when high
  logic [7:0] addr; // Register address
  logic [7:0] wdata; // Write data
  logic [7:0] rd_data; // Read data from device
  logic rd_oe; // Device drives read data
  logic ack; // Access acknowledge
  logic ack_oe; // Device drives acknowledge
  logic fault; // Fault pin, active high
  logic ind; // Shared indicator pin, active high
  logic [7:0] rd_bus; // Resolved read wires
  logic ack_bus; // Resolved acknowledge wire
  // Pulled up data, pulled down acknowledge when floating
  assign rd_bus = rd_oe ? rd_data : 8'hFF;
  assign ack_bus = ack_oe & ack;
  modport dev (input lk_clk, req, wr, addr, wdata, output rd_data, rd_oe, ack, ack_oe, fault, ind);
  modport ctrl (output lk_clk, req, wr, addr, wdata, input rd_bus, ack_bus, fault, ind);
endinterface

/* rtl/apm_sync.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Two flop synchroniser
// ----------------------------------------
module apm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg; // First stage, read only by second

  // Two stage capture
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_reg <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

/* rtl/apm_ctrl.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Link controller with APB registers
// ----------------------------------------
module apm_ctrl (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Link
  apm_link_if.ctrl lk
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] div; // Link clock divider
    logic lk_clk; // Link clock
    logic req; // Request level
    logic wr; // Direction
    logic [7:0] addr; // Link address
    logic [7:0] wdata; // Link write data
    logic [7:0] rdata; // Captured read data
    logic busy; // Access pending
    logic done; // Access finished
    apm_pkg::apm_cst_t cs; // Sequencer
    logic pready; // APB ready
    logic pslverr; // APB error
    logic [31:0] prdata; // APB read data
  } apm_ctl_t;

  apm_ctl_t st_reg;
  apm_ctl_t st_next;
  logic [10:0] syn; // Synchronised link inputs
  logic s_ack, s_flt, s_ind;
  logic [7:0] s_rd;

  assign {s_ack, s_flt, s_ind, s_rd} = syn;

  apm_sync #(.W(11)) u_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .d_i({lk.ack_bus, lk.fault, lk.ind, lk.rd_bus}),
    .q_o(syn)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic fall;
    logic setup, wr_acc;
    st_next = st_reg;
    fall = (st_reg.div == 5'(apm_pkg::LK_HALF - 1)) && st_reg.lk_clk;
    setup = psel_i & ~penable_i;
    wr_acc = psel_i & penable_i & st_reg.pready & pwrite_i;
    // Free running divided link clock
    if (st_reg.div == 5'(apm_pkg::LK_HALF - 1))
    begin
      st_next.div = 5'h00;
      st_next.lk_clk = ~st_reg.lk_clk;
    end
    else
      st_next.div = st_reg.div + 5'h01;
    // APB answer prepared in setup, given in access
    st_next.pready = setup;
    st_next.pslverr = 1'b0;
    if (setup)
    begin
      st_next.prdata = 32'h00000000;
      if (paddr_i == apm_pkg::A_LK_ADDR)
        st_next.prdata = {24'h000000, st_reg.addr};
      else if (paddr_i == apm_pkg::A_LK_WDATA)
        st_next.prdata = {24'h000000, st_reg.wdata};
      else if (paddr_i == apm_pkg::A_LK_GO)
        st_next.prdata = 32'h00000000;
      else if (paddr_i == apm_pkg::A_LK_STAT)
        st_next.prdata = {28'h0000000, s_ind, s_flt, st_reg.done, st_reg.busy};
      else if (paddr_i == apm_pkg::A_LK_RDATA)
        st_next.prdata = {24'h000000, st_reg.rdata};
      else
        st_next.pslverr = 1'b1;
    end
    // Writes take effect at the access edge; ignored while busy
    if (wr_acc && !st_reg.busy)
    begin
      if (paddr_i == apm_pkg::A_LK_ADDR)
        st_next.addr = pwdata_i[7:0];
      else if (paddr_i == apm_pkg::A_LK_WDATA)
        st_next.wdata = pwdata_i[7:0];
      else if (paddr_i == apm_pkg::A_LK_GO && (pwdata_i[apm_pkg::GO_WR] || pwdata_i[apm_pkg::GO_RD]))
      begin
        st_next.busy = 1'b1;
        st_next.done = 1'b0;
        st_next.wr = pwdata_i[apm_pkg::GO_WR];
      end
    end
    // Four phase link sequencer, request edges while link clock falls
    case (st_reg.cs)
      apm_pkg::CS_IDLE:
        if (st_reg.busy && fall)
        begin
          st_next.req = 1'b1;
          st_next.cs = apm_pkg::CS_REQ;
        end
      apm_pkg::CS_REQ:
        if (s_ack && fall)
        begin
          st_next.req = 1'b0;
          st_next.rdata = s_rd;
          st_next.cs = apm_pkg::CS_REL;
        end
      apm_pkg::CS_REL:
        if (!s_ack)
        begin
          st_next.busy = 1'b0;
          st_next.done = 1'b1;
          st_next.cs = apm_pkg::CS_IDLE;
        end
      default: st_next.cs = apm_pkg::CS_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_reg <= '0;
      st_reg.cs <= apm_pkg::CS_IDLE;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign lk.lk_clk = st_reg.lk_clk;
  assign lk.req = st_reg.req;
  assign lk.wr = st_reg.wr;
  assign lk.addr = st_reg.addr;
  assign lk.wdata = st_reg.wdata;
  assign prdata_o = st_reg.prdata;
  assign pready_o = st_reg.pready;
  assign pslverr_o = st_reg.pslverr;
endmodule

/* verif/apm_assertions.sv */
`timescale 1ns/1ps
module apm_assertions #(
  parameter int SC_CYC = 20
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Link wires
  input wire logic lk_clk,
  input wire logic req,
  input wire logic ack_bus,
  input wire logic fault,
  // Device pins
  input wire logic [3:0] peak_over_i,
  input wire logic [7:0] temp_i,
  input wire logic bat_high_i,
  input wire logic [3:0] drive_o
);
  // Run length of peak current on a driving channel
  logic [15:0] run_reg;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Restarts whenever no driving channel is over peak
  always_ff @(posedge clock_i or negedge nrst_i)
    if (!nrst_i)
      run_reg <= 16'h0000;
    else if ((peak_over_i & drive_o) == 4'h0)
      run_reg <= 16'h0000;
    else if (run_reg != 16'hFFFF)
      run_reg <= run_reg + 16'h0001;
  property p_req_fall;
    $changed(req) |-> !lk_clk;
  endproperty
  a_req_fall: assert property (p_req_fall) else $error("request moved with link clock high");
  property p_ack_req;
    $rose(ack_bus) |-> req;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("acknowledge without request");
  property p_ack_rise;
    $rose(req) |-> ##[1:40] ack_bus;
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("request not answered");
  property p_ack_hold;
    ack_bus && req |=> ack_bus;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("acknowledge dropped early");
  property p_ack_drop;
    $fell(req) |-> ##[1:40] !ack_bus;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("acknowledge not released");
  property p_ovr;
    bat_high_i |-> ##[1:6] (fault && drive_o == 4'h0);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overvoltage not acted on");
  property p_tsd;
    temp_i >= apm_pkg::TSD_TEMP |-> ##[1:6] (fault && drive_o == 4'h0);
  endproperty
  a_tsd: assert property (p_tsd) else $error("thermal shutdown missing");
  property p_sc_max;
    run_reg == SC_CYC + 8 |-> fault;
  endproperty
  a_sc_max: assert property (p_sc_max) else $error("short not shut down in time");
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
`define CK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  localparam int SC = 20;
  logic clock_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, por = 1'b0;
  logic [7:0] paddr_i = 8'h00, temp = 8'h19, lrd;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rdat;
  logic [3:0] avg = 4'h0, peak = 4'h0, fdut = 4'h0, twt = 4'h0, sup = 4'h0, drive_o, trim, plim;
  logic [3:0][7:0] dco = 32'h0000_0000;
  logic [3:0][1:0] gain;
  logic [1:0] asel = 2'h2, role;
  logic [6:0] badr;
  logic pready_o, pslverr_o, serr;
  int fails = 0, checked = 0;
  // Bus clock
  always #2.5 clock_i = ~clock_i;
  apm_link_if lk ();
  apm_device #(.SC_CYC(SC)) i_apm_device (.clock_i(clock_i), .nrst_i(nrst_i), .lk(lk), .addr_sel_i(asel),
    .avg_over_i(avg), .peak_over_i(peak), .full_duty_i(fdut), .tweet_det_i(twt), .dc_offset_i(dco), .temp_i(temp),
    .bat_low_i(sup[0]), .an_low_i(sup[1]), .pump_low_i(sup[2]), .bat_high_i(sup[3]), .por_i(por), .drive_o(drive_o),
    .pulse_trim_o(trim), .peak_limit_o(plim), .gain_o(gain), .osc_role_o(role), .bus_addr_o(badr));
  apm_ctrl i_apm_ctrl (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .lk(lk));
  apm_assertions #(.SC_CYC(SC)) i_apm_assertions (.clock_i(clock_i), .nrst_i(nrst_i), .lk_clk(lk.lk_clk), .req(lk.req),
    .ack_bus(lk.ack_bus), .fault(lk.fault), .peak_over_i(peak), .temp_i(temp), .bat_high_i(sup[3]), .drive_o(drive_o));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do
      @(posedge clock_i);
    while (pready_o !== 1'b1);
    rdat = prdata_o;
    serr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // One device register access over the link
  task automatic lk_op(input logic w, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, apm_pkg::A_LK_ADDR, {24'h000000, a});
    apb(1'b1, apm_pkg::A_LK_WDATA, {24'h000000, d});
    apb(1'b1, apm_pkg::A_LK_GO, w ? 32'h0000_0001 : 32'h0000_0002);
    do
      apb(1'b0, apm_pkg::A_LK_STAT, 32'h0000_0000);
    while (rdat[1:0] !== 2'h2);
    apb(1'b0, apm_pkg::A_LK_RDATA, 32'h0000_0000);
    lrd = rdat[7:0];
  endtask
  // All channels back to play
  task automatic ply;
    lk_op(1'b1, 8'h0C, 8'h0F);
  endtask
  task automatic print_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #400000;
    fails++;
    print_verdict;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    wt(10);
    nrst_i <= 1'b1;
    wt(4);
    `CK("role", 2'h2, role)
    `CK("addr", 7'h6E, badr)
    apb(1'b0, 8'h14, 32'h0000_0000);
    `CK("slverr", 1'b1, serr)
    lk_op(1'b0, 8'h0A, 8'h00);
    `CK("ind mode", 8'h00, lrd)
    lk_op(1'b0, 8'h06, 8'h00);
    `CK("dc en", 8'h00, lrd)
    lk_op(1'b1, 8'h05, 8'hE4);
    lk_op(1'b1, 8'h0C, 8'h0E);
    `CK("gain", 8'hE4, gain)
    `CK("mute", 4'hE, drive_o)
    ply;
    avg <= 4'h5;
    wt(6);
    `CK("trim", 4'h5, trim)
    `CK("drive", 4'hF, drive_o)
    avg <= 4'h0;
    $display("test setup done");
    peak <= 4'h2;
    wt(12);
    `CK("limit", 4'h2, plim)
    `CK("fault", 1'b0, lk.fault)
    peak <= 4'h0;
    wt(6);
    `CK("limit", 4'h0, plim)
    peak <= 4'h2;
    wt(40);
    `CK("drive", 4'hD, drive_o)
    `CK("fault", 1'b1, lk.fault)
    peak <= 4'h0;
    lk_op(1'b0, 8'h00, 8'h00);
    `CK("ch log", 8'h02, lrd)
    ply;
    `CK("drive", 4'hF, drive_o)
    `CK("fault", 1'b0, lk.fault)
    lk_op(1'b1, 8'h07, 8'h10);
    lk_op(1'b1, 8'h08, 8'h00);
    dco[2] <= 8'h0F;
    lk_op(1'b0, 8'h00, 8'h00);
    `CK("dc low", 8'h00, lrd)
    dco[2] <= 8'h10;
    lk_op(1'b0, 8'h00, 8'h00);
    `CK("dc log", 8'h40, lrd)
    `CK("drive", 4'hF, drive_o)
    lk_op(1'b1, 8'h06, 8'h01);
    `CK("drive", 4'hB, drive_o)
    `CK("fault", 1'b1, lk.fault)
    dco[2] <= 8'h00;
    ply;
    $display("test faults done");
    for (int m = 0; m < 4; m++)
      for (int t = 0; t < 2; t++)
      begin
        fdut <= t ? 4'h0 : 4'h8;
        temp <= t ? 8'h73 : 8'h19;
        lk_op(1'b1, 8'h0A, 8'(m));
        wt(6);
        `CK("ind", (m == 2) || (t ? m == 0 : m == 1), lk.ind)
      end
    twt <= 4'h4;
    wt(6);
    `CK("tweet", 1'b1, lk.ind)
    twt <= 4'h0;
    lk_op(1'b1, 8'h0A, 8'h00);
    temp <= 8'h87;
    wt(6);
    `CK("fold", 2'h0, gain[3])
    lk_op(1'b0, 8'h04, 8'h00);
    `CK("warn", 8'hE0, lrd)
    temp <= 8'h6A;
    lk_op(1'b0, 8'h04, 8'h00);
    `CK("warn", 8'h20, lrd)
    `CK("ind", 1'b1, lk.ind)
    temp <= 8'h68;
    wt(6);
    `CK("ind", 1'b0, lk.ind)
    $display("test indicator done");
    temp <= 8'h96;
    wt(8);
    lk_op(1'b0, 8'h01, 8'h00);
    `CK("tsd log", 8'h10, lrd)
    temp <= 8'h19;
    ply;
    `CK("drive", 4'hF, drive_o)
    for (int k = 0; k < 4; k++)
    begin
      sup <= 4'(1 << k);
      wt(8);
      `CK("fault", 1'b1, lk.fault)
      `CK("drive", 4'h0, drive_o)
      lk_op(1'b0, 8'h01, 8'h00);
      `CK("rail log", 8'(1 << k), lrd)
      sup <= 4'h0;
      ply;
      `CK("fault", 1'b0, lk.fault)
    end
    sup <= 4'h1;
    wt(8);
    `CK("w1c set", 1'b1, lk.fault)
    sup <= 4'h0;
    lk_op(1'b1, 8'h01, 8'h01);
    `CK("w1c fault", 1'b0, lk.fault)
    `CK("w1c drive", 4'hF, drive_o)
    por <= 1'b1;
    wt(6);
    `CK("float", 2'h0, {lk.rd_oe, lk.ack_oe})
    `CK("gain", 8'h00, gain)
    por <= 1'b0;
    wt(6);
    lk_op(1'b0, 8'h05, 8'h00);
    `CK("gain reg", 8'h00, lrd)
    $display("test supply done");
    print_verdict;
  end
endmodule
